// ### common/txsw_defines.vh
// Constants for the transmit status word writer: field positions, reset values, counts.
// Assumes a 125 MHz controller clock and a 32-bit descriptor memory port.
`ifndef TXSW_DEFINES_VH
`define TXSW_DEFINES_VH
`define TXSW_OWN_BIT 31
`define TXSW_ES_BIT 15
`define TXSW_LC_BIT 11
`define TXSW_NC_BIT 10
`define TXSW_LT_BIT 9
`define TXSW_EC_BIT 8
`define TXSW_CC_LSB 3
`define TXSW_ED_BIT 2
`define TXSW_DE_BIT 0
`define TXSW_COLL_WINDOW_BYTES 16'h0040
`define TXSW_MAX_COLLISIONS 5'h10
`define TXSW_DEFER_LIMIT_BITS 24288
// Deferral limit in clocks: 24288 bit times of 10 ns at an 8 ns clock.
`define TXSW_DEFER_LIMIT_CYC 18'h0_7698
`define TXSW_ST_IDLE 3'h0
`define TXSW_ST_FETCH 3'h1
`define TXSW_ST_XMIT 3'h2
`define TXSW_ST_CLOSE 3'h3
`define TXSW_ST_SUSP 3'h4
`define TXSW_ST_STOP 3'h5
`define TXSW_IRQ_CLOSED 0
`define TXSW_IRQ_SUSP 1
`define TXSW_IRQ_ERR 2
`define TXSW_WORD_RST 32'h0000_0000
`endif

// ### src/txsw_status_word.v
// Transmit status word engine: fetches the first descriptor word, runs ownership, and writes
// the closing status back in a single memory write.
// Assumes a memory port with one-cycle read latency, a MAC that reports transmit events as
// same-clock pulses, and a carrier sense pin from the transceiver that is asynchronous.
//
// Design decisions made here: the plain strobed port and the register addresses.
`include "txsw_defines.vh"
module txsw_status_word #(
   parameter AW = 32
) (
   // Clock and reset.
   input wire clk_sys_i,
   input wire rst_b_i,
   // Control from the channel.
   input wire start_i,
   input wire stop_i,
   input wire [AW-1:0] desc_addr_i,
   input wire defer_check_en_i,
   // Descriptor memory port.
   output reg mem_rd_o,
   output reg mem_wr_o,
   output reg [AW-1:0] mem_addr_o,
   output reg [31:0] mem_wdata_o,
   input wire [31:0] mem_rdata_i,
   // Transmit path events.
   output reg xmit_go_o,
   input wire xmit_done_i,
   input wire carrier_sense_i,
   input wire collision_i,
   input wire defer_bit_i,
   input wire [15:0] tx_byte_cnt_i,
   // State report.
   output reg suspended_o,
   output reg stopped_o,
   // Register port.
   input wire [3:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   // Interrupt.
   output reg irq_o
);
   localparam [3:0] OFS_STATUS = 4'h0;
   localparam [3:0] OFS_MASK = 4'h4;
   localparam [3:0] OFS_LAST = 4'h8;
   localparam [2:0] S_IDLE = `TXSW_ST_IDLE;
   localparam [2:0] S_FETCH = `TXSW_ST_FETCH;
   localparam [2:0] S_XMIT = `TXSW_ST_XMIT;
   localparam [2:0] S_CLOSE = `TXSW_ST_CLOSE;
   localparam [2:0] S_SUSP = `TXSW_ST_SUSP;
   localparam [2:0] S_STOP = `TXSW_ST_STOP;
   localparam [15:0] COLL_WIN = `TXSW_COLL_WINDOW_BYTES;
   localparam [4:0] MAX_COLL = `TXSW_MAX_COLLISIONS;
   // Bit time is 10 ns at 100 Mb/s, so the limit in clocks is bits times ten over eight.
   localparam [17:0] DEFER_CYC = `TXSW_DEFER_LIMIT_CYC;

   reg [2:0] state;
   reg csync_a;
   reg csync_b;
   reg seen_carrier;
   reg lost_carrier;
   reg late_coll;
   reg [4:0] coll_cnt;
   reg [17:0] defer_cnt;
   reg defer_ex;
   reg deferred;
   reg fetch_wait;
   reg [2:0] irq_stat;
   reg [2:0] irq_mask;
   reg [31:0] last_word;
   reg [2:0] ev;
   reg [31:0] next_word;

   // Two flip-flops bring the carrier pin into the clock domain.
   always @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         csync_a <= 1'b0;
         csync_b <= 1'b0;
      end else begin
         csync_a <= carrier_sense_i;
         csync_b <= csync_a;
      end
   end

   // Closing status word; reserved bits stay zero and every flag is written each time.
   always @* begin
      next_word = `TXSW_WORD_RST;
      next_word[`TXSW_OWN_BIT] = 1'b0;
      next_word[`TXSW_LC_BIT] = lost_carrier;
      next_word[`TXSW_NC_BIT] = ~seen_carrier;
      next_word[`TXSW_LT_BIT] = late_coll;
      next_word[`TXSW_EC_BIT] = (coll_cnt >= MAX_COLL);
      next_word[`TXSW_CC_LSB+3:`TXSW_CC_LSB] = coll_cnt[3:0];
      next_word[`TXSW_ED_BIT] = defer_ex;
      next_word[`TXSW_DE_BIT] = deferred;
      next_word[`TXSW_ES_BIT] = next_word[`TXSW_ED_BIT] | next_word[`TXSW_EC_BIT] |
         next_word[`TXSW_LT_BIT] | next_word[`TXSW_NC_BIT] | next_word[`TXSW_LC_BIT];
   end

   // Descriptor state machine with per-frame event trackers.
   always @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         state <= S_IDLE;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         mem_addr_o <= {AW{1'b0}};
         mem_wdata_o <= 32'h0000_0000;
         xmit_go_o <= 1'b0;
         suspended_o <= 1'b0;
         stopped_o <= 1'b1;
         seen_carrier <= 1'b0;
         lost_carrier <= 1'b0;
         late_coll <= 1'b0;
         coll_cnt <= 5'h00;
         defer_cnt <= 18'h0_0000;
         defer_ex <= 1'b0;
         deferred <= 1'b0;
         fetch_wait <= 1'b0;
         last_word <= 32'h0000_0000;
         ev <= 3'h0;
      end else begin
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         xmit_go_o <= 1'b0;
         ev <= 3'h0;
         case (state)
            S_IDLE, S_SUSP, S_STOP: begin
               suspended_o <= (state == S_SUSP);
               stopped_o <= (state != S_SUSP);
               if (start_i && !stop_i) begin
                  state <= S_FETCH;
                  mem_rd_o <= 1'b1;
                  mem_addr_o <= desc_addr_i;
                  fetch_wait <= 1'b1;
                  suspended_o <= 1'b0;
                  stopped_o <= 1'b0;
               end
            end
            S_FETCH: begin
               fetch_wait <= 1'b0;
               if (!fetch_wait) begin
                  if (mem_rdata_i[`TXSW_OWN_BIT]) begin
                     state <= S_XMIT;
                     xmit_go_o <= 1'b1;
                     seen_carrier <= 1'b0;
                     lost_carrier <= 1'b0;
                     late_coll <= 1'b0;
                     coll_cnt <= 5'h00;
                     defer_cnt <= 18'h0_0000;
                     defer_ex <= 1'b0;
                     deferred <= 1'b0;
                  end else begin
                     state <= S_SUSP;
                     suspended_o <= 1'b1;
                     ev[`TXSW_IRQ_SUSP] <= 1'b1;
                  end
               end
            end
            S_XMIT: begin
               if (csync_b) begin
                  seen_carrier <= 1'b1;
               end
               if (seen_carrier && !csync_b && !xmit_done_i) begin
                  lost_carrier <= 1'b1;
               end
               if (collision_i && coll_cnt < MAX_COLL) begin
                  coll_cnt <= coll_cnt + 5'h01;
               end
               if (collision_i && tx_byte_cnt_i > COLL_WIN) begin
                  late_coll <= 1'b1;
               end
               if (defer_bit_i) begin
                  deferred <= 1'b1;
                  if (defer_cnt != DEFER_CYC) begin
                     defer_cnt <= defer_cnt + 18'h0_0001;
                  end else if (defer_check_en_i) begin
                     defer_ex <= 1'b1;
                  end
               end
               if (xmit_done_i || late_coll || coll_cnt >= MAX_COLL || defer_ex) begin
                  state <= S_CLOSE;
               end
            end
            S_CLOSE: begin
               mem_wr_o <= 1'b1;
               mem_wdata_o <= next_word;
               last_word <= next_word;
               ev[`TXSW_IRQ_CLOSED] <= 1'b1;
               ev[`TXSW_IRQ_ERR] <= next_word[`TXSW_ES_BIT];
               state <= stop_i ? S_STOP : S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
         if (stop_i && state != S_XMIT && state != S_CLOSE) begin
            state <= S_STOP;
         end
      end
   end

   // Sticky events, write-one-to-clear, with a new event winning over a clear.
   always @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         irq_o <= 1'b0;
         reg_rdata_o <= 32'h0000_0000;
      end else begin
         if (reg_wr_i && reg_addr_i == OFS_STATUS) begin
            irq_stat <= (irq_stat & ~reg_wdata_i[2:0]) | ev;
         end else begin
            irq_stat <= irq_stat | ev;
         end
         if (reg_wr_i && reg_addr_i == OFS_MASK) begin
            irq_mask <= reg_wdata_i[2:0];
         end
         irq_o <= |(irq_stat & irq_mask);
         reg_rdata_o <= 32'h0000_0000;
         if (reg_rd_i) begin
            case (reg_addr_i)
               OFS_STATUS: reg_rdata_o <= {29'h0000_0000, irq_stat};
               OFS_MASK: reg_rdata_o <= {29'h0000_0000, irq_mask};
               OFS_LAST: reg_rdata_o <= last_word;
               default: reg_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // txsw_status_word

// ### sim/txsw_status_word_sva.sv
// Checker for the status word engine: fetch, suspend and the closing write.
// Assumes collisions and done pulses arrive only inside a frame.
module txsw_status_word_sva #(parameter AW = 32) (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Memory port and channel.
   input wire logic mem_rd_o,
   input wire logic mem_wr_o,
   input wire logic [AW-1:0] mem_addr_o,
   input wire logic [31:0] mem_wdata_o,
   input wire logic [31:0] mem_rdata_i,
   input wire logic [AW-1:0] desc_addr_i,
   // Transmit path.
   input wire logic xmit_go_o,
   input wire logic xmit_done_i,
   input wire logic collision_i,
   input wire logic [15:0] tx_byte_cnt_i,
   input wire logic suspended_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // A fetch and the ownership of the word it returns.
   sequence host_word_s;
      mem_rd_o ##1 !mem_rdata_i[31];
   endsequence
   sequence mover_word_s;
      mem_rd_o ##1 mem_rdata_i[31];
   endsequence
   fetch_addr_a: assert property (mem_rd_o |-> mem_addr_o == desc_addr_i)
      else $error("fetch address wrong");
   suspend_a: assert property (host_word_s |-> ##[1:3] suspended_o)
      else $error("no suspend on host word");
   start_xmit_a: assert property (mover_word_s |-> ##[1:3] xmit_go_o)
      else $error("owned word not sent");
   own_clear_a: assert property (mem_wr_o |-> !mem_wdata_o[31])
      else $error("ownership kept on close");
   rsvd_zero_a: assert property (mem_wr_o |->
      !(|mem_wdata_o[30:16]) && !(|mem_wdata_o[14:12]))
      else $error("reserved bits written");
   error_or_a: assert property (mem_wr_o |->
      mem_wdata_o[15] == |{mem_wdata_o[11:8], mem_wdata_o[2]})
      else $error("error summary wrong");
   close_write_a: assert property (xmit_done_i |-> ##[1:3] mem_wr_o && !mem_wdata_o[31])
      else $error("no closing write");
   late_coll_a: assert property (collision_i && tx_byte_cnt_i > 16'h0040 |->
      ##[1:4] mem_wr_o && mem_wdata_o[9])
      else $error("late collision missed");
endmodule // txsw_status_word_sva

bind txsw_status_word txsw_status_word_sva #(.AW(AW)) u_sva (.clk_sys_i(clk_sys_i),
   .rst_b_i(rst_b_i), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .desc_addr_i(desc_addr_i),
   .xmit_go_o(xmit_go_o), .xmit_done_i(xmit_done_i), .collision_i(collision_i),
   .tx_byte_cnt_i(tx_byte_cnt_i), .suspended_o(suspended_o));

// ### sim/txsw_host_mem.sv
// Host memory model holding the first word of one descriptor.
// Assumes the engine reads and writes on the controller clock.
module txsw_host_mem (
   // Clock.
   input wire logic clk_sys_i,
   // Memory port from the engine.
   input wire logic rd_i,
   input wire logic [31:0] word_i,
   output logic [31:0] rdata_o = 32'h0000_0000
);
   logic rd_d = 1'b0;
   // Data holds two cycles, then toggles every cycle, so a sample two cycles late sees its inverse.
   always @(posedge clk_sys_i) begin
      rd_d <= rd_i;
      rdata_o <= (rd_i || rd_d) ? word_i : ~rdata_o;
   end
endmodule // txsw_host_mem

// ### sim/txsw_status_word_bench.sv
// Bench for the status word engine: suspend, six frame outcomes, registers.
// Assumes the host memory model answers every fetch.
module txsw_status_word_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 0, rst_b_i = 0, start_i = 0, def_en = 0, done = 0, carr = 0;
   logic coll = 0, defer = 0, rd = 0, wr = 0, stp_req = 0;
   logic [15:0] bytes = 16'h0000;
   logic [3:0] ra = 4'h0;
   logic [31:0] wd = 32'h0000_0000, word = 32'h0000_0000, rdat;
   wire logic mrd, mwr, go, susp, stp, irq;
   wire logic [31:0] maddr, mwd, rdo, mdat;
   int err_total = 0, checks_done = 0;
   txsw_status_word u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .start_i(start_i),
      .stop_i(stp_req), .desc_addr_i(32'h0000_0040), .defer_check_en_i(def_en), .mem_rd_o(mrd),
      .mem_wr_o(mwr), .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mdat),
      .xmit_go_o(go), .xmit_done_i(done), .carrier_sense_i(carr), .collision_i(coll),
      .defer_bit_i(defer), .tx_byte_cnt_i(bytes), .suspended_o(susp), .stopped_o(stp),
      .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdo),
      .irq_o(irq));
   txsw_host_mem u_mem (.clk_sys_i(clk_sys_i), .rd_i(mrd), .word_i(word), .rdata_o(mdat));
   // Clock of 8 ns.
   initial forever #4 clk_sys_i = ~clk_sys_i;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (err_total == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task regw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask
   task regr(input logic [3:0] a);
      @(posedge clk_sys_i);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 rdat = rdo;
   endtask
   task kick;
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
   endtask
   // Waits for go (0), a write (1) or suspend (2) under a bound.
   task till(input int s, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (!(s == 0 ? go : s == 1 ? mwr : susp) && n < lim);
      chk({31'h0, n < lim}, 32'h0000_0001);
   endtask
   task t_suspend;
      word = 32'h7FFF_FFFF;
      kick;
      till(2, 20);
      regr(4'h0);
      chk(rdat & 32'h0000_0002, 32'h0000_0002);
      chk({31'h0, irq}, 32'h0);
      regw(4'h4, 32'h0000_0002);
      repeat (2) @(posedge clk_sys_i);
      chk({31'h0, irq}, 32'h0000_0001);
      regw(4'h0, 32'h0000_0002);
      repeat (2) @(posedge clk_sys_i);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, stp}, 32'h0);
      @(posedge clk_sys_i);
      stp_req <= 1'b1;
      @(posedge clk_sys_i);
      stp_req <= 1'b0;
      @(posedge clk_sys_i);
      #1 chk({31'h0, susp}, 32'h0);
      chk({31'h0, stp}, 32'h0000_0001);
   endtask
   // Mode 0 clean, 1 no carrier, 2 carrier lost, 3 late, 4 sixteen hits, 5 deferral.
   task t_frame(input int m, input logic [31:0] exp, input logic [31:0] msk);
      word = 32'hFFFF_FFFF;
      @(posedge clk_sys_i);
      carr <= (m != 1);
      def_en <= (m == 5);
      defer <= (m == 5);
      repeat (3) @(posedge clk_sys_i);
      kick;
      till(0, 20);
      @(posedge clk_sys_i);
      bytes <= (m == 3) ? 16'h0041 : 16'h0040;
      repeat ((m == 4) ? 16 : (m == 3)) begin
         @(posedge clk_sys_i);
         coll <= 1'b1;
         @(posedge clk_sys_i);
         coll <= 1'b0;
      end
      if (m < 3) begin
         repeat (5) @(posedge clk_sys_i);
         carr <= (m == 0);
         repeat (5) @(posedge clk_sys_i);
         done <= 1'b1;
         @(posedge clk_sys_i);
         done <= 1'b0;
      end
      till(1, 31000);
      chk(mwd & msk, exp);
      @(posedge clk_sys_i);
      defer <= 1'b0;
      bytes <= 16'h0000;
   endtask
   task t_regs;
      regr(4'h0);
      chk(rdat & 32'h0000_0007, 32'h0000_0005);
      regr(4'h8);
      chk(rdat, 32'h0000_8005);
      regr(4'hC);
      chk(rdat, 32'h0000_0000);
      regw(4'h0, 32'h0000_0007);
      regr(4'h0);
      chk(rdat & 32'h0000_0007, 32'h0000_0000);
   endtask
   // Main sequence.
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      #1 chk({31'h0, stp}, 32'h0000_0001);
      t_suspend;
      t_frame(0, 32'h0000_0000, 32'hFFFF_FFFF);
      t_frame(1, 32'h0000_8400, 32'hFFFF_FFFF);
      t_frame(2, 32'h0000_8800, 32'hFFFF_FFFF);
      t_frame(3, 32'h0000_8200, 32'hFFFF_FF87);
      t_frame(4, 32'h0000_8100, 32'hFFFF_FF87);
      t_frame(5, 32'h0000_8005, 32'hFFFF_FFFF);
      t_regs;
      summarize;
   end
   // Watchdog well beyond the longest deferral frame.
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      err_total++;
      summarize;
   end
endmodule // txsw_status_word_bench
